// ---- verilog/ddrcad_top.sv ----
// DDR4 command and address decoder with power state and write lane logic

module ddrcad_top (
  // Clock, reset and freeze
  input  wire logic                 ref_clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 ce_in,
  // Command and address pins
  input  wire logic                 cke_in,
  input  wire logic                 cs_n_in,
  input  wire logic                 act_n_in,
  input  wire logic                 ras_n_in,
  input  wire logic                 cas_n_in,
  input  wire logic                 we_n_in,
  input  wire logic                 bg_in,
  input  wire logic [1:0]           ba_in,
  input  wire logic [13:0]          addr_in,
  input  wire logic                 odt_in,
  // Mode settings
  input  wire logic                 otf_en_in,
  input  wire logic                 fixed_chop_in,
  input  wire logic                 rtt_nom_en_in,
  input  wire logic                 dbi_wr_en_in,
  input  wire logic                 dm_en_in,
  // Write data, two byte lanes
  input  wire logic [1:0]           beat_valid_in,
  input  wire logic [15:0]          beat_data_in,
  input  wire logic [1:0]           beat_pin_n_in,
  // Decoded command
  output ddrcad_pkg::ddrcad_cmd_t   cmd_out,
  output logic                      cmd_valid_out,
  // Bank and power state
  output logic [7:0]                banks_open_out,
  output logic [3:0]                pwr_state_out,
  output logic                      ca_buf_en_out,
  output logic                      odt_buf_en_out,
  // Burst and termination
  output logic                      burst_active_out,
  output logic [3:0]                beat_cnt_out,
  output logic                      rtt_nom_on_out,
  // Written beats
  output logic [1:0]                wbeat_valid_out,
  output logic [15:0]               wbeat_data_out
);

  ddrcad_pkg::ddrcad_pwr_t pwr_q, pwr_d;
  logic [7:0]  open_q;
  logic [7:0]  open_d;
  logic        cke_q;
  logic [3:0]  beats_left_q;
  logic [3:0]  beats_left_d;
  logic [2:0]  burst_bank_q;
  logic        burst_ap_q;
  logic        burst_wr_q;
  logic        awake;
  logic        sel;
  logic [2:0]  code;
  logic [2:0]  bank;
  logic        is_act;
  logic        is_rd;
  logic        is_wr;
  logic        is_pre;
  logic        is_mrs;
  logic        is_ref;
  logic        chop;
  logic        burst_end;
  logic [7:0]  bank_bit;
  logic [7:0]  close_mask;
  ddrcad_pkg::ddrcad_cmd_t cmd_d;

  // Inputs captured while awake: enable high now or at the last edge, so a
  // refresh sent with enable falling and all banks closed still enters self-refresh
  assign awake  = (pwr_q == ddrcad_pkg::DDRCAD_S_ON) & (cke_in | cke_q);
  assign sel    = awake & ~cs_n_in;
  assign code   = {ras_n_in, cas_n_in, we_n_in};
  assign bank   = {bg_in, ba_in};
  assign is_act = sel & ~act_n_in;
  assign is_rd  = sel & act_n_in
                  & (code == ddrcad_pkg::DDRCAD_C_RD);
  assign is_wr  = sel & act_n_in
                  & (code == ddrcad_pkg::DDRCAD_C_WR);
  assign is_pre = sel & act_n_in
                  & (code == ddrcad_pkg::DDRCAD_C_PRE);
  assign is_mrs = sel & act_n_in
                  & (code == ddrcad_pkg::DDRCAD_C_MRS);
  assign is_ref = sel & act_n_in
                  & (code == ddrcad_pkg::DDRCAD_C_REF);

  // Burst chop from A12 when on-the-fly, else from the fixed setting
  assign chop = otf_en_in ? ~addr_in[ddrcad_pkg::BC_BIT]
                          : fixed_chop_in;

  // Bank masks
  assign bank_bit  = 8'h01 << bank;
  assign burst_end = (beats_left_q == 4'h1) | (beats_left_q == 4'h2);
  assign close_mask =
      (is_pre & addr_in[ddrcad_pkg::AP_BIT]) ? 8'hFF :
      (is_pre ? bank_bit : 8'h00) |
      ((burst_end && burst_ap_q) ? (8'h01 << burst_bank_q) : 8'h00);

  // Decoded command fields
  always_comb
  begin
    cmd_d          = '0;
    cmd_d.act      = is_act;
    cmd_d.rd       = is_rd;
    cmd_d.wr       = is_wr;
    cmd_d.pre      = is_pre;
    cmd_d.pre_all  = is_pre & addr_in[ddrcad_pkg::AP_BIT];
    cmd_d.mrs      = is_mrs;
    cmd_d.refr     = is_ref;
    cmd_d.sre      = is_ref & ~cke_in;
    cmd_d.auto_pre = (is_rd | is_wr) & addr_in[ddrcad_pkg::AP_BIT];
    cmd_d.chop     = (is_rd | is_wr) & chop;
    cmd_d.bank     = bank;
    cmd_d.row      = {ras_n_in, cas_n_in, we_n_in, addr_in};
    cmd_d.col      = addr_in[9:0];
    cmd_d.mr_sel   = {bg_in, ba_in[1], ba_in[0]};
    cmd_d.opcode   = {3'h0, addr_in};
  end

  // Open bank bookkeeping
  always_comb
  begin
    open_d = (open_q & ~close_mask) | (is_act ? bank_bit : 8'h00);
  end

  // Burst beat counter, two beats per clock
  always_comb
  begin
    beats_left_d = beats_left_q;
    if (is_rd | is_wr)
      beats_left_d = chop ? ddrcad_pkg::BEATS_CHOP
                          : ddrcad_pkg::BEATS_FULL;
    else if (beats_left_q != 4'h0)
      beats_left_d = (beats_left_q > 4'h2) ? beats_left_q - 4'h2 : 4'h0;
  end

  // Power state: enable low enters power-down or self-refresh
  always_comb
  begin
    pwr_d = pwr_q;
    case (pwr_q)
      ddrcad_pkg::DDRCAD_S_ON:
        if (sel & act_n_in & (code == ddrcad_pkg::DDRCAD_C_REF) & ~cke_in
            & (open_q == 8'h00))
          pwr_d = ddrcad_pkg::DDRCAD_S_SR;
        else if (~cke_in)
          pwr_d = (open_q == 8'h00) ? ddrcad_pkg::DDRCAD_S_PPD
                                    : ddrcad_pkg::DDRCAD_S_APD;
      ddrcad_pkg::DDRCAD_S_PPD,
      ddrcad_pkg::DDRCAD_S_APD:
        if (cke_in)
          pwr_d = ddrcad_pkg::DDRCAD_S_ON;
      ddrcad_pkg::DDRCAD_S_SR:
        if (cke_in & ~cke_q)
          pwr_d = ddrcad_pkg::DDRCAD_S_ON;
      default:
        pwr_d = ddrcad_pkg::DDRCAD_S_ON;
    endcase
  end

  // Command and address capture on the rising edge
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cmd_out       <= '0;
      cmd_valid_out <= 1'b0;
    end
    else if (ce_in)
    begin
      cmd_out       <= cmd_d;
      cmd_valid_out <= is_act | is_rd | is_wr | is_pre | is_mrs | is_ref;
    end
  end

  // Bank, power and burst state
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pwr_q        <= ddrcad_pkg::DDRCAD_S_ON;
      open_q       <= ddrcad_pkg::BANKS_OPEN_RST;
      cke_q        <= 1'b0;
      beats_left_q <= 4'h0;
      burst_bank_q <= 3'h0;
      burst_ap_q   <= 1'b0;
      burst_wr_q   <= 1'b0;
    end
    else if (ce_in)
    begin
      pwr_q        <= pwr_d;
      open_q       <= open_d;
      cke_q        <= cke_in;
      beats_left_q <= beats_left_d;
      if (is_rd | is_wr)
      begin
        burst_bank_q <= bank;
        burst_ap_q   <= addr_in[ddrcad_pkg::AP_BIT];
        burst_wr_q   <= is_wr;
      end
      else if (burst_end)
        burst_ap_q   <= 1'b0;
    end
  end

  // Registered status outputs
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      banks_open_out   <= 8'h00;
      pwr_state_out    <= 4'h1;
      ca_buf_en_out    <= 1'b1;
      odt_buf_en_out   <= 1'b1;
      burst_active_out <= 1'b0;
      beat_cnt_out     <= 4'h0;
      rtt_nom_on_out   <= 1'b0;
    end
    else if (ce_in)
    begin
      banks_open_out   <= open_d;
      pwr_state_out    <= pwr_d;
      ca_buf_en_out    <= (pwr_d == ddrcad_pkg::DDRCAD_S_ON);
      odt_buf_en_out   <= (pwr_d != ddrcad_pkg::DDRCAD_S_SR);
      burst_active_out <= (beats_left_d != 4'h0);
      beat_cnt_out     <= beats_left_d;
      rtt_nom_on_out   <= rtt_nom_en_in & odt_in
                          & (pwr_q != ddrcad_pkg::DDRCAD_S_SR);
    end
  end

  // Per-lane write mask and inversion
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_lane
      ddrcad_wmask u_lane (
        .ref_clk_in     (ref_clk_in),
        .rst_in         (rst_in),
        .ce_in          (ce_in),
        .dbi_en_in      (dbi_wr_en_in),
        .dm_en_in       (dm_en_in),
        .wr_active_in   (burst_wr_q & (beats_left_q != 4'h0)),
        .beat_valid_in  (beat_valid_in[g]),
        .beat_data_in   (beat_data_in[8*g +: 8]),
        .beat_pin_n_in  (beat_pin_n_in[g]),
        .beat_valid_out (wbeat_valid_out[g]),
        .beat_data_out  (wbeat_data_out[8*g +: 8])
      );
    end
  endgenerate

  // Assertions
  sequence rd_cmd_s;
    ce_in && is_rd;
  endsequence

  cs_mask_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    ce_in && cs_n_in |=> !cmd_valid_out)
    else $error("Command taken with chip select high");
  act_row_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    ce_in && is_act |=> cmd_out.act
      && cmd_out.row[16:14] == $past({ras_n_in, cas_n_in, we_n_in}))
    else $error("Activate row high bits wrong");
  act_open_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    ce_in && is_act && !is_pre |=> banks_open_out[$past(bank)])
    else $error("Activated bank not open");
  pre_all_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    ce_in && is_pre && addr_in[10] |=> banks_open_out == 8'h00)
    else $error("Precharge all left a bank open");
  full_burst_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    rd_cmd_s ##0 (otf_en_in && addr_in[12]) |=> beat_cnt_out == 4'h8)
    else $error("Full burst length wrong");
  chop_burst_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    rd_cmd_s ##0 (otf_en_in && !addr_in[12]) |=> beat_cnt_out == 4'h4)
    else $error("Chopped burst length wrong");
  apd_entry_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    ce_in && pwr_q == ddrcad_pkg::DDRCAD_S_ON && !cke_in && open_q != 0
    && !is_ref |=> pwr_state_out == 4'h4)
    else $error("Active power-down not entered");
  sr_exit_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    ce_in && pwr_q == ddrcad_pkg::DDRCAD_S_SR && cke_in && !cke_q
    |=> pwr_state_out == 4'h1 && ca_buf_en_out)
    else $error("Self-refresh exit missed");
  rtt_gate_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    ce_in && !rtt_nom_en_in |=> !rtt_nom_on_out)
    else $error("Termination on while disabled");

endmodule

// ---- verilog/ddrcad_pkg.sv ----
// Package of constants and types for the DDR4 command and address decoder
package ddrcad_pkg;

  // Array organisation
  localparam int BG_COUNT     = 2;
  localparam int BANKS_PER_BG = 4;
  localparam int BANK_COUNT   = BG_COUNT * BANKS_PER_BG;
  localparam int ROW_W        = 17;
  localparam int COL_W        = 10;
  localparam int MR_SEL_W     = 3;
  localparam int OPCODE_W     = 17;

  // Burst lengths in data beats, and a full burst in core clocks
  localparam logic [3:0] BEATS_FULL  = 4'h8;
  localparam logic [3:0] BEATS_CHOP  = 4'h4;
  localparam logic [2:0] CORE_CLOCKS = 3'h4;

  // Address field positions
  localparam int AP_BIT  = 10;
  localparam int BC_BIT  = 12;
  localparam int MR_NUM1 = 1;

  // Mode register 5 bit that selects inversion on the mask pins
  localparam int MR5_DBI_WR_BIT = 12;
  localparam logic [2:0] MR5_SEL = 3'h5;
  localparam logic [2:0] MR1_SEL = 3'h1;

  // Reset values
  localparam logic [7:0] BANKS_OPEN_RST = 8'h00;

  // Command code on RAS#, CAS#, WE# with ACT# high
  typedef enum logic [2:0] {
    DDRCAD_C_MRS = 3'b000,
    DDRCAD_C_REF = 3'b001,
    DDRCAD_C_PRE = 3'b010,
    DDRCAD_C_RSV = 3'b011,
    DDRCAD_C_WR  = 3'b100,
    DDRCAD_C_RD  = 3'b101,
    DDRCAD_C_ZQ  = 3'b110,
    DDRCAD_C_NOP = 3'b111
  } ddrcad_code_t;

  // Power states, one-hot
  typedef enum logic [3:0] {
    DDRCAD_S_ON  = 4'b0001,
    DDRCAD_S_PPD = 4'b0010,
    DDRCAD_S_APD = 4'b0100,
    DDRCAD_S_SR  = 4'b1000
  } ddrcad_pwr_t;

  // Command and address pins as registered
  typedef struct packed {
    logic                cke;
    logic                cs_n;
    logic                act_n;
    logic                ras_n;
    logic                cas_n;
    logic                we_n;
    logic                bg;
    logic [1:0]          ba;
    logic [13:0]         addr;
    logic                odt;
  } ddrcad_ca_t;

  // Decoded access
  typedef struct packed {
    logic                act;
    logic                rd;
    logic                wr;
    logic                pre;
    logic                pre_all;
    logic                mrs;
    logic                refr;
    logic                sre;
    logic                auto_pre;
    logic                chop;
    logic [2:0]          bank;
    logic [ROW_W-1:0]    row;
    logic [COL_W-1:0]    col;
    logic [MR_SEL_W-1:0] mr_sel;
    logic [OPCODE_W-1:0] opcode;
  } ddrcad_cmd_t;

endpackage

// ---- verilog/ddrcad_wmask.sv ----
// Write beat mask and inversion handling for one byte lane
module ddrcad_wmask (
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic       ce_in,
  // Controls
  input  wire logic       dbi_en_in,
  input  wire logic       dm_en_in,
  input  wire logic       wr_active_in,
  // Beat in
  input  wire logic       beat_valid_in,
  input  wire logic [7:0] beat_data_in,
  input  wire logic       beat_pin_n_in,
  // Beat out
  output logic            beat_valid_out,
  output logic [7:0]      beat_data_out
);

  logic       keep;
  logic [7:0] data_fix;

  // Pin low masks the beat when masking is enabled and inversion is off, or with inversion selected flips it
  assign keep     = ~(dm_en_in & ~dbi_en_in & ~beat_pin_n_in);
  assign data_fix = (dbi_en_in & ~beat_pin_n_in) ? ~beat_data_in
                                                 : beat_data_in;

  // Register the surviving beat
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      beat_valid_out <= 1'b0;
      beat_data_out  <= 8'h00;
    end
    else if (ce_in)
    begin
      beat_valid_out <= beat_valid_in & wr_active_in & keep;
      beat_data_out  <= data_fix;
    end
  end

  masked_drop_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    ce_in && beat_valid_in && dm_en_in && !dbi_en_in && !beat_pin_n_in
    |=> !beat_valid_out) else $error("Masked beat was kept");
  inv_flip_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    ce_in && dbi_en_in && !beat_pin_n_in
    |=> beat_data_out == ~$past(beat_data_in))
    else $error("Inverted beat not flipped");

endmodule

// ---- tb/ddrcad_ctrl_model.sv ----
// Behavioural memory controller that drives the command and address pins
module ddrcad_ctrl_model (
  // Clock
  input  wire logic              ref_clk_in,
  // Pins towards the device
  output ddrcad_pkg::ddrcad_ca_t ca_out
);
  timeunit 1ns;
  timeprecision 100ps;

  ddrcad_pkg::ddrcad_ca_t ca_q;

  // Pins come straight from the register
  assign ca_out = ca_q;

  // Deselected and clock enabled at time zero
  initial
  begin
    ca_q = '0;
    ca_q.cke = 1'b1;
    ca_q.cs_n = 1'b1;
    ca_q.act_n = 1'b1;
  end

  // Drive one command for one clock, then deselect
  task automatic send(input logic cs_n, input logic cke, input logic act_n,
                      input logic [2:0] code, input logic [2:0] bank,
                      input logic [13:0] addr);
    @(posedge ref_clk_in);
    ca_q.cke <= (act_n && !code[1] && code[2]) ? 1'b1 : cke;
    ca_q.cs_n <= cs_n;
    ca_q.act_n <= act_n;
    {ca_q.ras_n, ca_q.cas_n, ca_q.we_n} <= code;
    {ca_q.bg, ca_q.ba} <= bank;
    ca_q.addr <= addr;
    @(posedge ref_clk_in);
    ca_q.cs_n <= 1'b1;
    ca_q.addr <= ~addr; // Stale address must not be trusted
  endtask

  // Change clock enable between commands
  task automatic set_cke(input logic v);
    @(posedge ref_clk_in);
    ca_q.cke <= v;
  endtask

  // Change the termination control pin
  task automatic set_odt(input logic v);
    @(posedge ref_clk_in);
    ca_q.odt <= v;
  endtask
endmodule

// ---- tb/tb_ddr4_command_address_decode.sv ----
// Self-checking bench for the command and address decoder
module tb_ddr4_command_address_decode;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk_in, rst_in, ce_in;
  logic otf_en, fixed_chop, rtt_en, dbi_en, dm_en;
  logic [1:0] bvalid, bpin_n, wvalid;
  logic [15:0] bdata, wdata;
  ddrcad_pkg::ddrcad_ca_t ca;
  ddrcad_pkg::ddrcad_cmd_t cmd;
  logic cmd_valid, ca_buf, odt_buf, burst, rtt_on;
  logic [7:0] banks_open;
  logic [3:0] pwr, beat_cnt;
  int err_count, comparisons;

  // Far side controller
  ddrcad_ctrl_model u_ctrl (.ref_clk_in(ref_clk_in), .ca_out(ca));

  // Device under test
  ddrcad_top DUT (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .cke_in(ca.cke), .cs_n_in(ca.cs_n), .act_n_in(ca.act_n),
    .ras_n_in(ca.ras_n), .cas_n_in(ca.cas_n), .we_n_in(ca.we_n),
    .bg_in(ca.bg), .ba_in(ca.ba), .addr_in(ca.addr), .odt_in(ca.odt),
    .otf_en_in(otf_en), .fixed_chop_in(fixed_chop),
    .rtt_nom_en_in(rtt_en), .dbi_wr_en_in(dbi_en), .dm_en_in(dm_en),
    .beat_valid_in(bvalid), .beat_data_in(bdata), .beat_pin_n_in(bpin_n),
    .cmd_out(cmd), .cmd_valid_out(cmd_valid), .banks_open_out(banks_open),
    .pwr_state_out(pwr), .ca_buf_en_out(ca_buf), .odt_buf_en_out(odt_buf),
    .burst_active_out(burst), .beat_cnt_out(beat_cnt),
    .rtt_nom_on_out(rtt_on), .wbeat_valid_out(wvalid),
    .wbeat_data_out(wdata)
  );

  // Free running 100 MHz clock
  initial
  begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  // Compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Print counts and verdict, then stop
  task automatic end_of_test;
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Wait a bounded time for a power state, then compare
  task automatic wait_pwr(input logic [3:0] exp);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge ref_clk_in);
      #1;
      if (pwr === exp)
        break;
    end
    chk(pwr, exp);
  endtask

  // Values seen after reset release
  task automatic t_reset;
    chk({pwr, banks_open, cmd_valid, ca_buf, odt_buf}, 32'h0000_0803);
  endtask

  // Activate every bank with a distinct row
  task automatic t_act;
    logic [16:0] row;
    for (int b = 0; b < 8; b++)
    begin
      row = {b[2:0], 14'h2A50 + b[13:0]};
      u_ctrl.send(1'b0, 1'b1, 1'b0, row[16:14], b[2:0], row[13:0]);
      #1;
      chk({cmd_valid, cmd.act, cmd.bank}, {27'h0, 1'b1, 1'b1, b[2:0]});
      chk(cmd.row, row);
      chk(banks_open[b], 1'b1);
    end
  endtask

  // Command with chip select high is masked
  task automatic t_csmask;
    u_ctrl.send(1'b1, 1'b1, 1'b0, 3'h0, 3'h0, 14'h0000);
    #1;
    chk(cmd_valid, 1'b0);
  endtask

  // Reads: column, burst length and auto-precharge
  task automatic t_read;
    otf_en <= 1'b1;
    u_ctrl.send(1'b0, 1'b1, 1'b1, 3'h5, 3'h3, 14'h1155);
    #1;
    chk({cmd.rd, cmd.auto_pre, cmd.chop, cmd.col}, {3'b100, 10'h155});
    chk(beat_cnt, 4'h8);
    @(posedge ref_clk_in);
    #1;
    chk(beat_cnt, 4'h6);
    u_ctrl.send(1'b0, 1'b1, 1'b1, 3'h5, 3'h3, 14'h0001);
    #1;
    chk({cmd.chop, beat_cnt}, {1'b1, 4'h4});
    otf_en <= 1'b0;
    fixed_chop <= 1'b1;
    u_ctrl.send(1'b0, 1'b1, 1'b1, 3'h5, 3'h3, 14'h1002);
    #1;
    chk(cmd.chop, 1'b1);
    fixed_chop <= 1'b0;
    u_ctrl.send(1'b0, 1'b1, 1'b1, 3'h5, 3'h5, 14'h0403);
    #1;
    chk({cmd.rd, cmd.auto_pre, banks_open[5]}, 3'b111);
    repeat (6) @(posedge ref_clk_in);
    #1;
    chk(banks_open, 8'hDF);
  endtask

  // Precharge one bank, then all banks
  task automatic t_pre;
    u_ctrl.send(1'b0, 1'b1, 1'b1, 3'h2, 3'h2, 14'h0000);
    @(posedge ref_clk_in);
    #1;
    chk(banks_open, 8'hDB);
    u_ctrl.send(1'b0, 1'b1, 1'b1, 3'h2, 3'h6, 14'h0400);
    #1;
    chk(cmd.pre_all, 1'b1);
    @(posedge ref_clk_in);
    #1;
    chk(banks_open, 8'h00);
  endtask

  // Mode register set to each register number
  task automatic t_mrs;
    for (int m = 0; m < 8; m++)
    begin
      u_ctrl.send(1'b0, 1'b1, 1'b1, 3'h0, m[2:0], 14'h00A5 + m[13:0]);
      #1;
      chk({cmd_valid, cmd.mrs, cmd.mr_sel}, {2'b11, m[2:0]});
      chk(cmd.opcode, {3'h0, 14'h00A5 + m[13:0]});
    end
  endtask

  // Power-down, refusal and self-refresh entry and exit
  task automatic t_power;
    u_ctrl.send(1'b0, 1'b1, 1'b0, 3'h0, 3'h1, 14'h0011);
    u_ctrl.set_cke(1'b0);
    wait_pwr(4'h4);
    chk({ca_buf, odt_buf}, 2'b01);
    u_ctrl.send(1'b0, 1'b0, 1'b0, 3'h0, 3'h2, 14'h0000);
    #1;
    chk(cmd_valid, 1'b0);
    u_ctrl.set_cke(1'b1);
    wait_pwr(4'h1);
    u_ctrl.send(1'b0, 1'b1, 1'b1, 3'h2, 3'h0, 14'h0400);
    u_ctrl.set_cke(1'b0);
    wait_pwr(4'h2);
    u_ctrl.set_cke(1'b1);
    wait_pwr(4'h1);
    u_ctrl.send(1'b0, 1'b0, 1'b1, 3'h1, 3'h0, 14'h0000);
    wait_pwr(4'h8);
    chk({ca_buf, odt_buf}, 2'b00);
    u_ctrl.set_cke(1'b1);
    wait_pwr(4'h1);
  endtask

  // Nominal termination follows the pin only when enabled
  task automatic t_odt;
    rtt_en <= 1'b1;
    u_ctrl.set_odt(1'b1);
    repeat (2) @(posedge ref_clk_in);
    #1;
    chk(rtt_on, 1'b1);
    rtt_en <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #1;
    chk(rtt_on, 1'b0);
    u_ctrl.set_odt(1'b0);
  endtask

  // One write beat with lane 0 pin low, lane 1 pin high
  task automatic wr_beat(input logic [1:0] exp_v, input logic [15:0] exp_d);
    u_ctrl.send(1'b0, 1'b1, 1'b1, 3'h4, 3'h0, 14'h0000);
    bvalid <= 2'b11;
    bdata <= 16'hC35A;
    bpin_n <= 2'b10;
    @(posedge ref_clk_in);
    bvalid <= 2'b00;
    #1;
    chk(wvalid, exp_v);
    chk(wdata & {{8{exp_v[1]}}, {8{exp_v[0]}}}, exp_d);
  endtask

  // Masking with inversion off, then inversion with masking off
  task automatic t_wbeat;
    dm_en <= 1'b1;
    dbi_en <= 1'b0;
    wr_beat(2'b10, 16'hC300);
    dm_en <= 1'b0;
    dbi_en <= 1'b1;
    wr_beat(2'b11, 16'hC3A5);
  endtask

  // Clock enable low freezes decoding; a mid-run reset clears all state
  task automatic t_freeze;
    ce_in <= 1'b0;
    u_ctrl.send(1'b0, 1'b1, 1'b0, 3'h0, 3'h4, 14'h0000);
    #1;
    chk({cmd_valid, banks_open}, 9'h000);
    ce_in <= 1'b1;
    u_ctrl.send(1'b0, 1'b1, 1'b0, 3'h0, 3'h4, 14'h0000);
    #1;
    chk({cmd_valid, banks_open}, 9'h110);
    rst_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    #1;
    t_reset();
    u_ctrl.send(1'b0, 1'b1, 1'b0, 3'h0, 3'h2, 14'h0000);
    #1;
    chk({cmd_valid, banks_open}, 9'h104);
  endtask

  // Watchdog cuts a hang short
  initial
  begin
    #200us;
    err_count++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    err_count = 0;
    comparisons = 0;
    rst_in = 1'b1;
    ce_in = 1'b1;
    {otf_en, fixed_chop, rtt_en, dbi_en, dm_en} = 5'h00;
    bvalid = 2'b00;
    bdata = 16'h0000;
    bpin_n = 2'b11;
    repeat (4) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    #1;
    t_reset();
    t_act();
    t_csmask();
    t_read();
    t_pre();
    t_mrs();
    t_power();
    t_odt();
    t_wbeat();
    t_freeze();
    end_of_test();
  end
endmodule
